// *** rtl/thermal_alarm_pkg.sv ***
// Package with constants shared by the thermal alarm and power status logic.
package thermal_alarm_pkg;
   // Synchroniser depth for pin inputs.
   localparam int SYNC_STAGES = 3;
   // Reset value of the throttle engage flag.
   localparam logic THROTTLE_RST = 1'b0;
   // Reset value of the active-low status output and synchroniser stages (released).
   localparam logic PIN_IDLE_N = 1'b1;
   // Drive source encoding for the alarm pin.
   typedef enum logic [1:0]
   {
      SRC_NONE     = 2'b00,
      SRC_INTERNAL = 2'b01,
      SRC_EXTERNAL = 2'b10,
      SRC_BOTH     = 2'b11
   } throttle_src_e;
endpackage

// *** rtl/alarm_sync_if.sv ***
// Interface carrying the synchronised alarm pin level between modules.
`timescale 1ns/1ps
interface alarm_sync_if;
   logic pin_raw_n;
   logic pin_low;
   logic pin_low_valid;
   modport sync
   (
      input  pin_raw_n,
      output pin_low,
      output pin_low_valid
   );
   modport user
   (
      output pin_raw_n,
      input  pin_low,
      input  pin_low_valid
   );
endinterface

// *** rtl/alarm_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter for the alarm line.
`timescale 1ns/1ps
module alarm_pin_sync
   import thermal_alarm_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   sys_rst,
   alarm_sync_if.sync  sif
);
   // ------------------------------------------------------------
   // Synchroniser chain
   // ------------------------------------------------------------
   logic [SYNC_STAGES-1:0] stage_reg;
   logic                   level_reg;

   // Shift the raw pin level through the chain; first stage feeds only the second.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         stage_reg <= {SYNC_STAGES{PIN_IDLE_N}};
      else
         stage_reg <= {stage_reg[SYNC_STAGES-2:0], sif.pin_raw_n};
   end

   // Accept a new level only when the second and third stages agree.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         level_reg <= 1'b0;
      else if (stage_reg[1] == stage_reg[2])
         level_reg <= ~stage_reg[2];
   end

   assign sif.pin_low       = level_reg;
   assign sif.pin_low_valid = (stage_reg[1] == stage_reg[2]);
endmodule

// *** rtl/thermal_alarm_power_status.sv ***
// Thermal alarm line and low-power status sideband logic.
`timescale 1ns/1ps
module thermal_alarm_power_status
   import thermal_alarm_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic over_temp,
   input  wire logic throttle_enable,
   input  wire logic deepest_sleep,
   input  wire logic thermal_alarm_n_in,
   output logic      thermal_alarm_n_out,
   output logic      thermal_alarm_n_oe,
   output logic      thermal_throttle_unit_active,
   output logic      throttle_from_external,
   output logic      low_power_status_n
);
   // ------------------------------------------------------------
   // Input conditioning
   // ------------------------------------------------------------
   alarm_sync_if sif ();

   assign sif.pin_raw_n = thermal_alarm_n_in;

   // Synchronise the shared alarm line into the core clock domain.
   alarm_pin_sync u_sync
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .sif      (sif)
   );

   logic over_temp_reg;
   logic drive_reg;
   logic drive_d_reg;
   logic ext_low;

   // Register the internal monitor result; it is same-clock logic.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         over_temp_reg <= 1'b0;
      else
         over_temp_reg <= over_temp;
   end

   // Remember own drive over the synchroniser latency so it is not mistaken for
   // an external assertion when our drive is released.
   logic [SYNC_STAGES:0] own_hist_reg;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         own_hist_reg <= '0;
      else
         own_hist_reg <= {own_hist_reg[SYNC_STAGES-1:0], drive_reg};
   end

   // An assertion counts as external only while our own drive is absent.
   assign ext_low = sif.pin_low && !drive_reg && (own_hist_reg == '0);

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   // Pull the alarm line low while the die is at its limit.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         drive_reg <= 1'b0;
      else
         drive_reg <= over_temp_reg;
   end

   // Open-drain pin: output level is always low, enable marks drive.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         thermal_alarm_n_out <= 1'b0;
         thermal_alarm_n_oe  <= 1'b0;
      end
      else
      begin
         thermal_alarm_n_out <= 1'b0;
         thermal_alarm_n_oe  <= over_temp_reg;
      end
   end

   // ------------------------------------------------------------
   // Throttle control
   // ------------------------------------------------------------
   throttle_src_e src;
   logic          ext_hold_reg;

   // External hold stays set until the synchronised line reads high again, even while own drive holds it low, or the throttle is disabled.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         ext_hold_reg <= THROTTLE_RST;
      else if (throttle_enable && ext_low)
         ext_hold_reg <= 1'b1;
      else if (!sif.pin_low || !throttle_enable)
         ext_hold_reg <= 1'b0;
   end

   assign src = throttle_src_e'({ext_hold_reg, drive_reg});

   // Engage the throttle unit for any enabled source.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         thermal_throttle_unit_active <= THROTTLE_RST;
         throttle_from_external       <= 1'b0;
      end
      else
      begin
         case (src)
            SRC_NONE:
            begin
               thermal_throttle_unit_active <= 1'b0;
               throttle_from_external       <= 1'b0;
            end
            SRC_INTERNAL:
            begin
               thermal_throttle_unit_active <= throttle_enable;
               throttle_from_external       <= 1'b0;
            end
            SRC_EXTERNAL, SRC_BOTH:
            begin
               thermal_throttle_unit_active <= throttle_enable;
               throttle_from_external       <= throttle_enable;
            end
            default:
            begin
               thermal_throttle_unit_active <= 1'b0;
               throttle_from_external       <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Low-power status
   // ------------------------------------------------------------
   // Signal light load to the regulator while in the deepest sleep state.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         low_power_status_n <= PIN_IDLE_N;
      else
         low_power_status_n <= ~deepest_sleep;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // These watch inputs as well as registered state and stay quiet while reset is held.
   // Each delay matches the register stages of the path that it guards.

   // The pin is sunk two edges after the monitor reports its limit.
   AST_DRIVE_FOLLOWS_TEMP: assert property (@(posedge core_clk) disable iff (sys_rst)
      over_temp |-> ##2 thermal_alarm_n_oe)
      else $error("Alarm not driven two cycles after over temperature.");

   // The pin is released two edges after the die cools.
   AST_NO_DRIVE_COOL: assert property (@(posedge core_clk) disable iff (sys_rst)
      !over_temp |-> ##2 !thermal_alarm_n_oe)
      else $error("Alarm driven without over temperature.");

   // The open-drain level stays low whenever the pin is enabled.
   AST_OUT_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
      thermal_alarm_n_oe |-> !thermal_alarm_n_out)
      else $error("Alarm pin enabled with a high level.");

   // Own drive with an enabled unit engages the throttle on the next edge.
   AST_DRIVE_THROTTLES: assert property (@(posedge core_clk) disable iff (sys_rst)
      (drive_reg && throttle_enable) |=> thermal_throttle_unit_active)
      else $error("Driven alarm without engaged throttle.");

   // An accepted external assertion engages the throttle two edges later.
   AST_EXT_ENGAGE: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ext_low && throttle_enable)
         |-> ##2 (thermal_throttle_unit_active || !$past(throttle_enable)))
      else $error("External alarm did not engage throttle.");

   // A disabled unit never engages, whatever the source.
   AST_DISABLED_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst)
      !throttle_enable |=> !thermal_throttle_unit_active)
      else $error("Throttle engaged while disabled.");

   // The external flag only stands after the wire was seen low.
   AST_EXT_NEEDS_WIRE: assert property (@(posedge core_clk) disable iff (sys_rst)
      throttle_from_external |-> $past(sif.pin_low, 2))
      else $error("External throttle flagged without a low wire.");

   // The external hold survives as long as the wire stays low and the unit is enabled.
   AST_EXT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ext_hold_reg && sif.pin_low && throttle_enable) |=> ext_hold_reg)
      else $error("External throttle dropped while line held.");

   // Releasing the wire clears the external flag within two edges.
   AST_EXT_RELEASE: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!sif.pin_low && !drive_reg) |-> ##2 !throttle_from_external)
      else $error("External throttle kept after release.");

   // Deepest sleep asserts the low-power status on the next edge.
   AST_LOW_POWER: assert property (@(posedge core_clk) disable iff (sys_rst)
      deepest_sleep |=> !low_power_status_n)
      else $error("Low-power status not asserted in deepest sleep.");

   // The filtered level only moves after the last two stages agreed.
   AST_SYNC_SETTLED: assert property (@(posedge core_clk) disable iff (sys_rst)
      $changed(sif.pin_low) |-> $past(sif.pin_low_valid))
      else $error("Synchronised level moved before the stages agreed.");

   // Own drive never sets the external hold.
   AST_OWN_IGNORED: assert property (@(posedge core_clk) disable iff (sys_rst)
      drive_reg |=> !ext_hold_reg || $past(ext_hold_reg))
      else $error("Own drive taken as external assertion.");
endmodule

// *** verification/board_thermal_partner.sv ***
// Board-side thermal manager model sharing the open-drain alarm wire.
`timescale 1ns/1ps
module board_thermal_partner
(
   input  wire logic dev_out,
   input  wire logic dev_oe,
   input  wire logic sys_pull,
   output logic      wire_n
);
   // The wire has a pull-up, so it rests high unless some party sinks it.
   assign wire_n = ((dev_oe && !dev_out) || sys_pull) ? 1'h0 : 1'h1;
endmodule

// *** verification/test_thermal_alarm_power_status.sv ***
// Self-checking bench for the thermal alarm and low-power status logic.
`timescale 1ns/1ps
module test_thermal_alarm_power_status
   import thermal_alarm_pkg::*;
;
   logic core_clk        = 1'h0;
   logic sys_rst         = 1'h1;
   logic over_temp       = 1'h0;
   logic throttle_enable = 1'h0;
   logic deepest_sleep   = 1'h0;
   logic sys_pull        = 1'h0;
   logic wire_n, a_out, a_oe, thr, thr_ext, lps_n;
   int   err_total       = 0;
   int   n_checks        = 0;
   int   i;

   // Free-running 50 ns clock.
   always #25 core_clk = ~core_clk;

   // Device under test and the board model on the alarm wire.
   thermal_alarm_power_status u_thermal_alarm_power_status
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .over_temp(over_temp),
      .throttle_enable(throttle_enable), .deepest_sleep(deepest_sleep),
      .thermal_alarm_n_in(wire_n), .thermal_alarm_n_out(a_out),
      .thermal_alarm_n_oe(a_oe), .thermal_throttle_unit_active(thr),
      .throttle_from_external(thr_ext), .low_power_status_n(lps_n)
   );
   board_thermal_partner u_board_thermal_partner
   (
      .dev_out(a_out), .dev_oe(a_oe), .sys_pull(sys_pull), .wire_n(wire_n)
   );

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input string nm, input logic seen, input logic exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", nm, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Waits at most 12 cycles for the throttle level; a timeout ends the run.
   task automatic wait_thr(input logic v);
      for (int k = 0; k < 12 && thr !== v; k++)
         @(negedge core_clk);
      check("throttle wait", thr, v);
      if (thr !== v)
         print_verdict();
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Over-temperature makes the device sink the wire, with or without throttling.
   task automatic sc_internal(input logic en);
      @(negedge core_clk);
      throttle_enable = en;
      over_temp = 1'h1;
      repeat (2) @(negedge core_clk);
      check("oe", a_oe, 1'h1);
      check("out", a_out, 1'h0);
      repeat (4) @(negedge core_clk);
      check("thr int", thr, en);
      check("ext own", thr_ext, 1'h0);
      over_temp = 1'h0;
      wait_thr(1'h0);
      for (i = 0; i < 8; i++)
      begin
         @(negedge core_clk);
         check("ext after", thr_ext, 1'h0);
      end
      check("oe off", a_oe, 1'h0);
   endtask

   // The board pulls the wire; throttling follows only when enabled and holds.
   task automatic sc_external(input logic en);
      @(negedge core_clk);
      throttle_enable = en;
      sys_pull = 1'h1;
      @(negedge core_clk);
      check("sync lag", thr, 1'h0);
      if (en)
         wait_thr(1'h1);
      for (i = 0; i < 20; i++)
      begin
         @(negedge core_clk);
         check("thr hold", thr, en);
         check("ext flag", thr_ext, en);
      end
      check("oe ext", a_oe, 1'h0);
      sys_pull = 1'h0;
      wait_thr(1'h0);
      repeat (6) @(negedge core_clk);
      check("ext clr", thr_ext, 1'h0);
   endtask

   // The board holds the wire while the die overheats; the hold outlasts own drive.
   task automatic sc_both();
      @(negedge core_clk);
      throttle_enable = 1'h1;
      sys_pull = 1'h1;
      wait_thr(1'h1);
      over_temp = 1'h1;
      for (i = 0; i < 14; i++)
      begin
         @(negedge core_clk);
         check("both thr", thr, 1'h1);
         check("both ext", thr_ext, 1'h1);
         if (i == 5)
         begin
            check("both oe", a_oe, 1'h1);
            over_temp = 1'h0;
         end
      end
      check("both oe off", a_oe, 1'h0);
      sys_pull = 1'h0;
      wait_thr(1'h0);
      check("both ext clr", thr_ext, 1'h0);
   endtask

   // Deepest sleep drives the low-power status one edge later.
   task automatic sc_sleep();
      @(negedge core_clk);
      deepest_sleep = 1'h1;
      @(negedge core_clk);
      check("lps on", lps_n, 1'h0);
      deepest_sleep = 1'h0;
      @(negedge core_clk);
      check("lps off", lps_n, 1'h1);
   endtask

   // Main sequence: reset, then every scenario.
   initial
   begin
      repeat (10) @(negedge core_clk);
      check("rst oe", a_oe, 1'h0);
      check("rst thr", thr, THROTTLE_RST);
      check("rst ext", thr_ext, 1'h0);
      check("rst lps", lps_n, PIN_IDLE_N);
      sys_rst = 1'h0;
      sc_internal(1'h1);
      sc_internal(1'h0);
      sc_external(1'h1);
      sc_external(1'h0);
      sc_both();
      sc_sleep();
      print_verdict();
   end
endmodule
